/* hw/irx_pkg.sv */
// constants, field layouts and types shared by the infrared codec files
// Function
// [RULE1] While enabled, encode UART output to pulses and decode pulses to UART input.
// [RULE2] The link is half-duplex; sending and receiving never overlap.
// [RULE3] Bit rate comes from the baud generator; 9600 to 115.2 kbps is compliant.
// [RULE4] Software enables the UART first; the codec has no serial engine.
// [RULE5] Encoder times every bit as sixteen baud-clock periods from the UART output.
// [RULE6] A transmitted one keeps the pulse output low for all sixteen clocks.
// [RULE7] A transmitted zero is low seven, high three, low six clocks.
// [RULE8] Software clears receive enable while transmitting to avoid crosstalk.
// [RULE9] The receive decoder works only while receive enable is set.
// [RULE10] Software never lets the UART transmit while the decoder is enabled.
// [RULE11] Decoder uses sixteen clocks per bit; valid low pulse gives delayed low bit.
// [RULE12] Pulses wider than five baud clocks are always discarded.
// [RULE13] Minimum-width code zero skips the narrow check; any edge is a pulse.
// [RULE14] Minimum-width code sits in control bits 7:4; non-zero enables the check.
// [RULE15] Six-bit down-counter loads code in upper bits and three below.
// [RULE16] With the check on, pulses shorter than the count in system clocks are ignored.
// [RULE17] Software sets code to int((fsys*wmin-3)/4), or zero below one.
// [RULE18] First received bit may jitter; later bits are exactly sixteen clocks wide.
// [RULE19] Receive enable is control bit 1; when clear the infrared input is ignored.
// [RULE20] While disabled, pulse output stays low and UART input idles high.
// [RULE21] The infrared input is synchronised before widths or edges are measured.
package irx_pkg;
	// register bus geometry; printed offsets are word indices
	localparam int ADDR_W = 12;
	localparam logic [9:0] CTRL_IDX = 10'h0bf;
	localparam logic [9:0] STAT_IDX = 10'h0c0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control register layout
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RXEN_BIT = 1;
	localparam int CTRL_LOOP_BIT = 2;
	localparam int MINW_LSB = 4;
	localparam int MINW_MSB = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hf7;
	// status register layout
	localparam int STAT_RXD_BIT = 0;
	localparam int STAT_TXACT_BIT = 1;
	localparam int STAT_CLASH_BIT = 2;
	// bit timing in baud-clock periods; MINW_LOW is the minimum-width count's low bits, in system clocks
	localparam logic [3:0] BIT_LAST = 4'hf;
	localparam logic [3:0] PULSE_FIRST = 4'h7;
	localparam logic [3:0] PULSE_LAST = 4'h9;
	localparam logic [2:0] WIDE_MAX = 3'h5;
	localparam logic [1:0] MINW_LOW = 2'h3;
	// decoder pulse tracker
	typedef enum logic [1:0] {
		IRX_IDLE,
		IRX_PULSE,
		IRX_REJECT
	} irx_rx_e;
endpackage

/* hw/irx_sync.sv */
// two-flop synchroniser for the infrared receive pin
module irx_sync (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	import irx_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
	} irx_sync_s;

	irx_sync_s s;
	irx_sync_s next_s;

	// the idle level of the pin is high, so reset to high
	always_comb begin
		next_s.s1 = async_in;
		next_s.s2 = s.s1; // [RULE21]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{s1: 1'b1, s2: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign sync_out = s.s2;
endmodule

/* hw/irx_enc.sv */
// return-to-zero pulse encoder driven by the sixteen-times baud tick
module irx_enc (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic enable,
	input wire logic baud_tick,
	// serial in, pulse out
	input wire logic uart_txd,
	output logic ir_pulse_out
);
	import irx_pkg::*;

	typedef struct packed {
		logic [3:0] phase;
		logic bit_val;
		logic out;
	} irx_enc_s;

	irx_enc_s s;
	irx_enc_s next_s;

	// a change of the serial line restarts the phase, so bit cells follow the uart
	always_comb begin
		next_s = s;
		if (!enable) begin
			next_s.phase = '0;
			next_s.bit_val = 1'b1;
			next_s.out = 1'b0; // [RULE20]
		end else begin
			if (baud_tick) begin
				if (uart_txd != s.bit_val) begin
					next_s.phase = '0;
					next_s.bit_val = uart_txd;
				end else begin
					next_s.phase = s.phase + 4'h1; // wraps after sixteen ticks [RULE5]
				end
			end
			// ones stay low, zeros pulse high in phases 7..9 [RULE6] [RULE7] [RULE1]
			next_s.out = !s.bit_val && (s.phase >= PULSE_FIRST) && (s.phase <= PULSE_LAST);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{phase: 4'h0, bit_val: 1'b1, out: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign ir_pulse_out = s.out;
endmodule

/* hw/irx_top.sv */
// infrared codec top: register slave, pulse decoder and encoder hookup
module irx_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [irx_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [irx_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// uart side
	input wire logic baud_tick,
	input wire logic uart_txd,
	output logic uart_rxd,
	// transceiver pins
	output logic ir_pulse_out,
	input wire logic ir_pulse_in
);
	import irx_pkg::*;

	typedef struct packed {
		// register slave
		logic [7:0] ctrl;
		logic clash;
		logic aw_held;
		logic [9:0] aw_idx;
		logic w_held;
		logic [7:0] w_byte;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		// decoder
		irx_rx_e st;
		logic prev_lvl;
		logic [5:0] minw_cnt;
		logic min_ok;
		logic [2:0] wide_cnt;
		logic busy;
		logic pend;
		logic [3:0] out_cnt;
		logic rxd;
	} irx_top_s;

	irx_top_s s;
	irx_top_s next_s;

	logic pin_lvl;
	logic rx_lvl;
	logic enc_out;
	logic en;
	logic rx_en;
	logic loop_en;
	logic [3:0] minw_code;
	logic accept;
	logic [7:0] stat_val;

	// word index of a byte address
	function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

	// register read view, zero for unmapped
	function automatic logic [31:0] reg_view(input logic [9:0] idx, input logic [7:0] c,
		input logic [7:0] st);
		if (idx == CTRL_IDX) begin
			return {24'h000000, c};
		end else if (idx == STAT_IDX) begin
			return {24'h000000, st};
		end
		return 32'h00000000;
	endfunction

	function automatic logic is_mapped(input logic [9:0] idx);
		return (idx == CTRL_IDX) || (idx == STAT_IDX);
	endfunction

	// pin passes two flops before any edge or width logic
	irx_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(ir_pulse_in),
		.sync_out(pin_lvl)
	);

	// encoder runs straight off the uart output; it has no serial engine of its own
	irx_enc u_enc (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(en),
		.baud_tick(baud_tick),
		.uart_txd(uart_txd),
		.ir_pulse_out(enc_out)
	);

	// control decode
	assign en = s.ctrl[CTRL_EN_BIT];
	assign rx_en = s.ctrl[CTRL_RXEN_BIT];
	assign loop_en = s.ctrl[CTRL_LOOP_BIT];
	assign minw_code = s.ctrl[MINW_MSB:MINW_LSB];

	// loopback feeds the inverted encoder output back; it is on-chip, no sync needed
	assign rx_lvl = loop_en ? ~enc_out : pin_lvl;

	// status view of the block's own state
	always_comb begin
		stat_val = 8'h00;
		stat_val[STAT_RXD_BIT] = s.rxd;
		stat_val[STAT_TXACT_BIT] = en && !uart_txd;
		stat_val[STAT_CLASH_BIT] = s.clash;
	end

	// handshake outputs are combinational; one write and one read in flight
	assign awready = !s.aw_held && !s.bvalid;
	assign wready = !s.w_held && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign uart_rxd = s.rxd;
	assign ir_pulse_out = enc_out;

	// a pulse ending low-to-high after meeting the minimum width is a zero bit
	assign accept = (s.st == IRX_PULSE) && !s.prev_lvl && rx_lvl && s.min_ok;

	always_comb begin
		next_s = s;

		// write address and data are held separately, either may come first
		if (awvalid && awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_idx = word_idx(awaddr);
		end
		if (wvalid && wready) begin
			next_s.w_held = 1'b1;
			next_s.w_byte = wdata[7:0];
			next_s.w_lane0 = wstrb[0];
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = is_mapped(s.aw_idx) ? RESP_OKAY : RESP_SLVERR;
			if (s.w_lane0 && s.aw_idx == CTRL_IDX) begin
				next_s.ctrl = s.w_byte & CTRL_WMASK; // reserved bit 3 stays zero [RULE14]
			end
			if (s.w_lane0 && s.aw_idx == STAT_IDX && s.w_byte[STAT_CLASH_BIT]) begin
				next_s.clash = 1'b0;
			end
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// reads answer one cycle after the address is taken
		if (arvalid && arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = reg_view(word_idx(araddr), s.ctrl, stat_val);
			next_s.rresp = is_mapped(word_idx(araddr)) ? RESP_OKAY : RESP_SLVERR;
		end else if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end

		// overlap of uart transmit and enabled decoder is flagged when loopback is off; set beats clear
		if (en && rx_en && !loop_en && !uart_txd) begin
			next_s.clash = 1'b1; // [RULE2] [RULE10]
		end

		next_s.prev_lvl = rx_lvl;

		if (!(en && rx_en)) begin
			// decoder idle: input ignored, uart sees a steady idle high [RULE9] [RULE19] [RULE20]
			next_s.st = IRX_IDLE;
			next_s.min_ok = 1'b0;
			next_s.minw_cnt = '0;
			next_s.wide_cnt = '0;
			next_s.busy = 1'b0;
			next_s.pend = 1'b0;
			next_s.out_cnt = '0;
			next_s.rxd = 1'b1;
		end else begin
			// pulse tracker; pulses are low on rx_lvl, the synchronised pin or the inverted loopback [RULE11]
			case (s.st)
				IRX_IDLE: begin
					if (s.prev_lvl && !rx_lvl) begin
						next_s.st = IRX_PULSE;
						next_s.minw_cnt = {minw_code, MINW_LOW}; // [RULE15]
						next_s.min_ok = (minw_code == 4'h0); // edge alone suffices [RULE13]
						next_s.wide_cnt = '0;
					end
				end
				IRX_PULSE: begin
					if (rx_lvl) begin
						next_s.st = IRX_IDLE;
					end else begin
						// count system clocks while low; short pulses never set min_ok [RULE16]
						if (s.minw_cnt > 6'h01) begin
							next_s.minw_cnt = s.minw_cnt - 6'h01;
						end else begin
							next_s.min_ok = 1'b1;
						end
						if (baud_tick) begin
							if (s.wide_cnt == WIDE_MAX) begin
								next_s.st = IRX_REJECT; // [RULE12]
							end else begin
								next_s.wide_cnt = s.wide_cnt + 3'h1;
							end
						end
					end
				end
				IRX_REJECT: begin
					// too wide: wait for the line to return high and drop it
					if (rx_lvl) begin
						next_s.st = IRX_IDLE;
					end
				end
				default: begin
					next_s.st = IRX_IDLE;
				end
			endcase

			// output shaper: each accepted pulse gives a sixteen-tick low bit [RULE1]
			if (s.busy) begin
				if (accept) begin
					next_s.pend = 1'b1;
				end
				if (baud_tick) begin
					next_s.out_cnt = s.out_cnt + 4'h1;
					if (s.out_cnt == BIT_LAST) begin
						// back-to-back zeros chain on the tick grid, exactly sixteen wide [RULE18]
						if (s.pend || accept) begin
							next_s.pend = 1'b0;
						end else begin
							next_s.busy = 1'b0;
							next_s.rxd = 1'b1;
						end
					end
				end
			end else if (accept) begin
				// the first bit starts at the pulse end, so it may jitter by a tick
				next_s.busy = 1'b1;
				next_s.out_cnt = '0;
				next_s.rxd = 1'b0;
			end
		end
	end

	// the uart's baud generator paces both directions [RULE3] [RULE5]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '{
				ctrl: CTRL_RST,
				clash: 1'b0,
				aw_held: 1'b0,
				aw_idx: 10'h000,
				w_held: 1'b0,
				w_byte: 8'h00,
				w_lane0: 1'b0,
				bvalid: 1'b0,
				bresp: RESP_OKAY,
				rvalid: 1'b0,
				rdata: 32'h00000000,
				rresp: RESP_OKAY,
				st: IRX_IDLE,
				prev_lvl: 1'b1,
				minw_cnt: 6'h00,
				min_ok: 1'b0,
				wide_cnt: 3'h0,
				busy: 1'b0,
				pend: 1'b0,
				out_cnt: 4'h0,
				rxd: 1'b1
			};
		end else begin
			s <= next_s;
		end
	end
endmodule

/* tb/irx_top_sva.sv */
// assertion checker for the infrared codec top
module irx_top_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// codec pins
	input wire logic baud_tick,
	input wire logic uart_txd,
	input wire logic uart_rxd,
	input wire logic ir_pulse_out,
	input wire logic ir_pulse_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] hi_cnt;
	logic [3:0] in_age;
	logic [3:0] last_lo;
	logic [5:0] rx_lo;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// tick counts of the pulse runs, so widths are judged in bit sixteenths; in_age counts clocks since the input was low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_cnt <= 4'h0;
			in_age <= 4'hf;
			last_lo <= 4'h0;
			rx_lo <= 6'h00;
		end else begin
			hi_cnt <= ir_pulse_out ? hi_cnt + 4'(baud_tick) : 4'h0;
			in_age <= !ir_pulse_in ? 4'h0 : in_age + 4'(in_age != 4'hf);
			if (!ir_pulse_in && in_age != 4'h0) begin
				last_lo <= 4'(baud_tick);
			end else if (!ir_pulse_in && baud_tick && last_lo != 4'hf) begin
				last_lo <= last_lo + 4'h1;
			end
			rx_lo <= uart_rxd ? 6'h00 : rx_lo + 6'(baud_tick);
		end
	end
	a_tx_pulse_width: assert property ($fell(ir_pulse_out) |-> hi_cnt == 4'h3)
		else $error("encoder pulse not three ticks wide");
	a_tx_one_quiet: assert property ($rose(ir_pulse_out) |-> !$past(uart_txd, 2))
		else $error("encoder pulse during a one bit");
	a_rx_cause: assert property ($fell(uart_rxd) |-> in_age <= 4'h6)
		else $error("decoded low without a recent input pulse");
	a_rx_wide_drop: assert property ($fell(uart_rxd) |-> last_lo <= 4'h6)
		else $error("wide input pulse was decoded");
	a_rx_bit_len: assert property ($rose(uart_rxd) |-> rx_lo >= 6'h0f
		&& rx_lo[3:0] inside {4'hf, 4'h0, 4'h1})
		else $error("decoded low is not whole bits");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_r_latency: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_w_latency: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	c_tx_pulse: cover property ($rose(ir_pulse_out));
	c_rx_bit: cover property ($fell(uart_rxd));
	c_read: cover property (rvalid && rready);
endmodule

bind irx_top irx_top_sva irx_top_sva_inst (.aclk, .aresetn, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
	.baud_tick, .uart_txd, .uart_rxd, .ir_pulse_out, .ir_pulse_in);

/* tb/irx_xcvr_model.sv */
// transceiver model: idle high line with low receive pulses of a chosen width
module irx_xcvr_model (
	// clock
	input wire logic aclk,
	// pulse request
	input wire logic fire,
	input wire logic [7:0] width,
	// line toward the codec
	output logic ir_pulse_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left = 8'h00;
	// only sends when asked by fire; it does not look at whether the device transmits
	always @(posedge aclk) begin
		if (fire) begin
			left <= width;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end
	assign ir_pulse_in = (left == 8'h00); // idle high between pulses
endmodule

/* tb/tb_irx_top.sv */
// self-checking bench for the infrared codec top
module tb_irx_top;
	timeunit 1ns;
	timeprecision 1ns;
	import irx_pkg::*;
	localparam logic [11:0] CTRL_A = {CTRL_IDX, 2'b00};
	localparam logic [11:0] STAT_A = {STAT_IDX, 2'b00};
	localparam logic [33:0] OK = {RESP_OKAY, 32'h0};
	// bus, uart and pin signals
	logic aclk = 1'b0, aresetn = 1'b0, baud_tick = 1'b0, uart_txd = 1'b1, fire = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, uart_rxd, ir_pulse_out, ir_pulse_in;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'h000122ca; // xorshift start value 74442
	logic [1:0] bresp, rresp, tdiv = 2'h0;
	logic [7:0] width = 8'h0, b;
	logic [33:0] exp_q[$];
	logic last_rxd = 1'b1, last_out = 1'b0;
	int error_cnt = 0, checks_done = 0, rx_falls = 0, tx_pulses = 0, n, m;
	irx_top irx_top_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
		.wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .baud_tick,
		.uart_txd, .uart_rxd, .ir_pulse_out, .ir_pulse_in);
	irx_xcvr_model irx_xcvr_model_inst (.aclk, .fire, .width, .ir_pulse_in);
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] e);
		checks_done++;
		if (seen !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, e, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one bus transfer; ready is sampled mid-cycle, where it has settled for the edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] e);
		logic ta, tw, tq, tr;
		exp_q.push_back(e);
		@(posedge aclk);
		awvalid <= wr;
		wvalid <= wr;
		bready <= wr;
		arvalid <= !wr;
		rready <= !wr;
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		tr = 1'b0;
		for (int i = 0; i < 200 && !tr; i++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tq = arvalid && arready;
			tr = (bvalid && bready) || (rvalid && rready);
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tq) arvalid <= 1'b0;
			if (tr) bready <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		if (!tr) begin
			error_cnt++;
			stop_test();
		end
	endtask
	// uart frame, lsb first, sixteen ticks of four clocks per bit
	task automatic send_frame(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			uart_txd <= f[i];
			repeat (64) @(posedge aclk);
		end
	endtask
	initial begin
		forever #25 aclk = ~aclk;
	end
	// baud tick every fourth clock stands in for the baud generator
	always @(posedge aclk) begin
		tdiv <= tdiv + 2'h1;
		baud_tick <= (tdiv == 2'h3);
	end
	// response scoreboard and pin edge counters
	always @(posedge aclk) begin
		last_rxd <= uart_rxd;
		last_out <= ir_pulse_out;
		if (last_rxd && !uart_rxd) rx_falls++;
		if (!last_out && ir_pulse_out) tx_pulses++;
		if ((bvalid && bready) || (rvalid && rready)) begin
			if (exp_q.size() == 0) begin
				check("spare response", 34'h0, 34'h1);
			end else if (bvalid) begin
				check("bresp", {bresp, 32'h0}, exp_q.pop_front());
			end else begin
				check("rdata", {rresp, rdata}, exp_q.pop_front());
			end
		end
	end
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
	// decode table: control value, pulse clocks, pulses expected; code 2 counts 11 clocks
	logic [7:0] dc[5] = '{8'h03, 8'h23, 8'h23, 8'h03, 8'h01};
	logic [7:0] dw[5] = '{8'h02, 8'h08, 8'h0e, 8'h28, 8'h08};
	logic da[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		bus(1'b0, CTRL_A, 32'h0, OK); // reset value
		bus(1'b1, CTRL_A, 32'hff, OK); // full write
		bus(1'b0, CTRL_A, 32'h0, {RESP_OKAY, 32'hf7}); // reserved bit
		bus(1'b1, CTRL_A, 32'h0, OK); // codec off
		bus(1'b0, STAT_A, 32'h0, {RESP_OKAY, 32'h1}); // idle line
		bus(1'b0, 12'h004, 32'h0, {RESP_SLVERR, 32'h0}); // unmapped
		bus(1'b1, 12'h004, 32'h1, {RESP_SLVERR, 32'h0}); // unmapped
		b = 8'(rnd());
		n = tx_pulses;
		send_frame(b);
		check("off pulses", 34'(tx_pulses - n), 34'h0); // silent when off
		bus(1'b1, CTRL_A, 32'h1, OK); // receive off to send
		n = tx_pulses;
		m = rx_falls;
		send_frame(b);
		check("tx pulses", 34'(tx_pulses - n), 34'(9 - $countones(b))); // zeros
		check("rx quiet", 34'(rx_falls - m), 34'h0); // receive off
		dw[0] = 8'h02 + 8'(rnd() % 10);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, CTRL_A, {24'h0, dc[i]}, OK); // width code
			m = rx_falls;
			fire <= 1'b1;
			width <= dw[i];
			@(posedge aclk);
			fire <= 1'b0;
			repeat (120) @(posedge aclk);
			check("rx pulse", 34'(rx_falls - m), 34'(da[i]));
		end
		// deliberate overlap of uart transmit and enabled decoder sets the sticky flag
		bus(1'b1, CTRL_A, 32'h3, OK); // decoder on
		uart_txd <= 1'b0;
		bus(1'b0, STAT_A, 32'h0, {RESP_OKAY, 32'h7}); // overlap flagged
		uart_txd <= 1'b1;
		bus(1'b1, STAT_A, 32'h4, OK); // write one clears
		bus(1'b0, STAT_A, 32'h0, {RESP_OKAY, 32'h1}); // flag gone, line idle
		stop_test();
	end
endmodule
